// ==== logic/dwc_defs.svh ====
// constants for the waveform core: word layout, bit positions, timing
`ifndef DWC_DEFS_SVH
`define DWC_DEFS_SVH

`define DWC_WORD_BITS     16
`define DWC_CNT_BITS      5
`define DWC_FREQ_BITS     28
`define DWC_HALF_BITS     14
`define DWC_PHASE_BITS    12
`define DWC_DAC_BITS      10

`define DWC_ADDR_HI       15
`define DWC_ADDR_LO       14
`define DWC_ADDR_CTRL     2'h0
`define DWC_ADDR_FREQ_A   2'h1
`define DWC_ADDR_FREQ_B   2'h2
`define DWC_ADDR_PHASE    2'h3

`define DWC_BIT_FULL      13
`define DWC_BIT_HALF      12
`define DWC_BIT_FSEL      11
`define DWC_BIT_PSEL      10
`define DWC_BIT_RESET     8
`define DWC_BIT_CLKSLP    7
`define DWC_BIT_DACSLP    6
`define DWC_BIT_OPBIT     5
`define DWC_BIT_SQUARE_DIVIDE_CTRL      3
`define DWC_BIT_MODE      1
`define DWC_BIT_PHSEL     13

`define DWC_ACC_TOP       27
`define DWC_ACC_CUT       16
`define DWC_START_CYCLES  4'h8
`define DWC_MIDSCALE      10'h200
`define DWC_SINE_TOP      9'h1ff
`define DWC_PH_MSB        11
`define DWC_PH_QTR        10
`define DWC_QIDX_HI       9
`define DWC_QIDX_LO       5
`define DWC_TRI_LO        1

`endif

// ==== logic/dwc_pkg.sv ====
// types shared by the waveform core
`include "dwc_defs.svh"

package dwc_pkg;

    typedef struct packed {
        logic full_word_load;
        logic half_select;
        logic freq_word_select;
        logic phase_word_select;
        logic soft_reset;
        logic clock_sleep;
        logic converter_sleep;
        logic output_bit_enable;
        logic square_divide_ctrl;
        logic triangle_mode;
    } dwc_ctrl_t;

    typedef enum logic {
        DWC_IDLE,
        DWC_SHIFT
    } dwc_state_t;

    typedef struct packed {
        logic       sclk;
        logic       frame_sync_n;
        logic       serial_in;
    } dwc_pins_t;

endpackage

// ==== logic/dwc_core.sv ====
// numerically controlled waveform core with serial register port
`timescale 1ns/10ps
`default_nettype none

module dwc_core
    import dwc_pkg::*;
(
    // clock, reset, enable
    input  wire logic                        sys_clk_i,
    input  wire logic                        nrst_i,
    input  wire logic                        ce_i,
    // serial write port
    input  wire logic                        sclk_i,
    input  wire logic                        frame_sync_n_i,
    input  wire logic                        serial_in_i,
    // waveform and power status
    output logic [`DWC_DAC_BITS-1:0]         wave_out_o,
    output logic                             converter_sleep_o,
    output logic                             clock_running_o
);

    // quarter-wave sine amplitude, 32 points
    function automatic logic [8:0] sine_lookup(input logic [4:0] idx);
        logic [8:0] amp;
        amp = 9'h000;
        unique case (idx)
            5'h00: amp = 9'h00d;
            5'h01: amp = 9'h026;
            5'h02: amp = 9'h03f;
            5'h03: amp = 9'h057;
            5'h04: amp = 9'h070;
            5'h05: amp = 9'h088;
            5'h06: amp = 9'h0a0;
            5'h07: amp = 9'h0b8;
            5'h08: amp = 9'h0cf;
            5'h09: amp = 9'h0e6;
            5'h0a: amp = 9'h0fc;
            5'h0b: amp = 9'h111;
            5'h0c: amp = 9'h126;
            5'h0d: amp = 9'h13a;
            5'h0e: amp = 9'h14e;
            5'h0f: amp = 9'h160;
            5'h10: amp = 9'h172;
            5'h11: amp = 9'h183;
            5'h12: amp = 9'h193;
            5'h13: amp = 9'h1a2;
            5'h14: amp = 9'h1b0;
            5'h15: amp = 9'h1bd;
            5'h16: amp = 9'h1c8;
            5'h17: amp = 9'h1d3;
            5'h18: amp = 9'h1dd;
            5'h19: amp = 9'h1e5;
            5'h1a: amp = 9'h1ed;
            5'h1b: amp = 9'h1f3;
            5'h1c: amp = 9'h1f8;
            5'h1d: amp = 9'h1fb;
            5'h1e: amp = 9'h1fe;
            5'h1f: amp = 9'h1ff;
        endcase
        return amp;
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    dwc_pins_t pins_meta_q;
    dwc_pins_t pins_sync_q;
    logic      sclk_last_q;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pins_meta_q <= '{sclk: 1'b1, frame_sync_n: 1'b1, serial_in: 1'b0};
            pins_sync_q <= '{sclk: 1'b1, frame_sync_n: 1'b1, serial_in: 1'b0};
            sclk_last_q <= 1'b1;
        end else if (ce_i) begin
            pins_meta_q <= '{sclk: sclk_i, frame_sync_n: frame_sync_n_i,
                             serial_in: serial_in_i};
            pins_sync_q <= pins_meta_q;
            sclk_last_q <= pins_sync_q.sclk;
        end
    end

    // ------------------------------------------------------------------
    // serial shifter
    // ------------------------------------------------------------------
    dwc_state_t                    state_q;
    dwc_state_t                    state_d;
    logic [`DWC_WORD_BITS-1:0]     shift_q;
    logic [`DWC_CNT_BITS-1:0]      count_q;

    wire sclk_fall  = sclk_last_q & ~pins_sync_q.sclk;
    wire framed     = ~pins_sync_q.frame_sync_n;
    wire bit_take   = framed & sclk_fall;
    wire last_bit   = (count_q == 5'(`DWC_WORD_BITS - 1));
    wire word_done  = (state_q == DWC_SHIFT) & bit_take & last_bit;
    wire [`DWC_WORD_BITS-1:0] word_in = {shift_q[`DWC_WORD_BITS-2:0],
                                         pins_sync_q.serial_in};

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            DWC_IDLE:  if (framed) state_d = DWC_SHIFT;
            DWC_SHIFT: if (!framed || word_done) state_d = DWC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= DWC_IDLE;
            shift_q <= 16'h0000;
            count_q <= 5'h00;
        end else if (ce_i) begin
            state_q <= state_d;
            if (!framed || word_done) begin
                count_q <= 5'h00;
            end else if (bit_take) begin
                shift_q <= word_in;
                count_q <= count_q + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // word decode
    // ------------------------------------------------------------------
    wire [1:0] word_addr = word_in[`DWC_ADDR_HI:`DWC_ADDR_LO];
    wire [`DWC_HALF_BITS-1:0]  word_half  = word_in[`DWC_HALF_BITS-1:0];
    wire [`DWC_PHASE_BITS-1:0] word_phase = word_in[`DWC_PHASE_BITS-1:0];

    wire wr_ctrl  = word_done & (word_addr == `DWC_ADDR_CTRL);
    wire wr_fa    = word_done & (word_addr == `DWC_ADDR_FREQ_A);
    wire wr_fb    = word_done & (word_addr == `DWC_ADDR_FREQ_B);
    wire wr_phase = word_done & (word_addr == `DWC_ADDR_PHASE);
    wire wr_pa    = wr_phase & ~word_in[`DWC_BIT_PHSEL];
    wire wr_pb    = wr_phase &  word_in[`DWC_BIT_PHSEL];
    wire wr_freq  = wr_fa | wr_fb;

    // ------------------------------------------------------------------
    // control, frequency and phase registers
    // ------------------------------------------------------------------
    dwc_ctrl_t                   ctrl_q;
    logic [`DWC_FREQ_BITS-1:0]   frequency_word_a_q;
    logic [`DWC_FREQ_BITS-1:0]   frequency_word_b_q;
    logic [`DWC_PHASE_BITS-1:0]  phase_offset_a_q;
    logic [`DWC_PHASE_BITS-1:0]  phase_offset_b_q;
    logic [`DWC_HALF_BITS-1:0]   low_hold_q;
    logic                        low_pending_q;
    logic                        pending_b_q;

    wire dwc_ctrl_t ctrl_d = '{
        full_word_load:     word_in[`DWC_BIT_FULL],
        half_select:        word_in[`DWC_BIT_HALF],
        freq_word_select:   word_in[`DWC_BIT_FSEL],
        phase_word_select:  word_in[`DWC_BIT_PSEL],
        soft_reset:         word_in[`DWC_BIT_RESET],
        clock_sleep:        word_in[`DWC_BIT_CLKSLP],
        converter_sleep:    word_in[`DWC_BIT_DACSLP],
        output_bit_enable:  word_in[`DWC_BIT_OPBIT],
        square_divide_ctrl: word_in[`DWC_BIT_SQUARE_DIVIDE_CTRL],
        triangle_mode:      word_in[`DWC_BIT_MODE]
    };

    // second write of a full-word pair: same address as the held first half
    wire pair_hit   = low_pending_q & (pending_b_q == wr_fb);
    wire full_low   = wr_freq & ctrl_q.full_word_load & ~pair_hit;
    wire full_high  = wr_freq & ctrl_q.full_word_load &  pair_hit;
    wire half_write = wr_freq & ~ctrl_q.full_word_load;

    // new value for whichever frequency word is addressed
    wire [`DWC_FREQ_BITS-1:0] freq_cur = wr_fb ? frequency_word_b_q
                                               : frequency_word_a_q;
    wire [`DWC_FREQ_BITS-1:0] freq_half_d = ctrl_q.half_select
        ? {word_half, freq_cur[`DWC_HALF_BITS-1:0]}
        : {freq_cur[`DWC_FREQ_BITS-1:`DWC_HALF_BITS], word_half};
    wire [`DWC_FREQ_BITS-1:0] freq_d = full_high ? {word_half, low_hold_q}
                                                 : freq_half_d;
    wire freq_load = full_high | half_write;

    // writes are taken regardless of clock sleep
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= '0;
        end else if (ce_i && wr_ctrl) begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frequency_word_a_q <= 28'h000_0000;
            frequency_word_b_q <= 28'h000_0000;
        end else if (ce_i && freq_load) begin
            if (wr_fb) frequency_word_b_q <= freq_d;
            else       frequency_word_a_q <= freq_d;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_hold_q    <= 14'h0000;
            low_pending_q <= 1'b0;
            pending_b_q   <= 1'b0;
        end else if (ce_i) begin
            if (full_low) begin
                low_hold_q    <= word_half;
                low_pending_q <= 1'b1;
                pending_b_q   <= wr_fb;
            end else if (full_high || half_write || wr_ctrl) begin
                low_pending_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_offset_a_q <= 12'h000;
            phase_offset_b_q <= 12'h000;
        end else if (ce_i) begin
            if (wr_pa) phase_offset_a_q <= word_phase;
            if (wr_pb) phase_offset_b_q <= word_phase;
        end
    end

    // ------------------------------------------------------------------
    // accumulator and phase path
    // ------------------------------------------------------------------
    logic [`DWC_FREQ_BITS-1:0] acc_q;
    logic [3:0]                start_q;
    logic                      msb_last_q;
    logic                      half_sq_q;

    wire run     = ~ctrl_q.clock_sleep;
    wire advance = run & ~ctrl_q.soft_reset;
    wire [`DWC_FREQ_BITS-1:0] freq_sel = ctrl_q.freq_word_select
                                       ? frequency_word_b_q
                                       : frequency_word_a_q;
    wire [`DWC_PHASE_BITS-1:0] phase_sel = ctrl_q.phase_word_select
                                         ? phase_offset_b_q
                                         : phase_offset_a_q;
    wire [`DWC_PHASE_BITS-1:0] phase_pt =
        acc_q[`DWC_ACC_TOP:`DWC_ACC_CUT] + phase_sel;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_q <= 28'h000_0000;
        end else if (ce_i && run) begin
            if (ctrl_q.soft_reset) acc_q <= 28'h000_0000;
            else                   acc_q <= acc_q + freq_sel;
        end
    end

    // restart delay after the reset bit clears
    wire started = (start_q == `DWC_START_CYCLES);

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            start_q <= 4'h0;
        end else if (ce_i && run) begin
            if (ctrl_q.soft_reset) start_q <= 4'h0;
            else if (!started)     start_q <= start_q + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // waveform shaping
    // ------------------------------------------------------------------
    wire [4:0] quarter_idx = phase_pt[`DWC_PH_QTR] ? ~phase_pt[`DWC_QIDX_HI:`DWC_QIDX_LO]
                                                   : phase_pt[`DWC_QIDX_HI:`DWC_QIDX_LO];
    wire [8:0] sine_amp    = sine_lookup(quarter_idx);
    wire [`DWC_DAC_BITS-1:0] sine_code = phase_pt[`DWC_PH_MSB]
        ? {1'b0, `DWC_SINE_TOP - sine_amp}
        : {1'b1, sine_amp};
    wire [`DWC_DAC_BITS-1:0] tri_code  = phase_pt[`DWC_PH_MSB]
        ? ~phase_pt[`DWC_PH_QTR:`DWC_TRI_LO]
        : phase_pt[`DWC_PH_QTR:`DWC_TRI_LO];
    wire data_msb  = phase_pt[`DWC_PH_MSB];
    wire msb_rise  = data_msb & ~msb_last_q;
    wire sq_bit    = ctrl_q.square_divide_ctrl ? data_msb : half_sq_q;
    wire [`DWC_DAC_BITS-1:0] sq_code = {`DWC_DAC_BITS{sq_bit}};
    wire [`DWC_DAC_BITS-1:0] shaped = ctrl_q.output_bit_enable ? sq_code
                                    : ctrl_q.triangle_mode ? tri_code
                                    : sine_code;
    wire [`DWC_DAC_BITS-1:0] wave_d = started ? shaped : `DWC_MIDSCALE;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            msb_last_q <= 1'b0;
            half_sq_q  <= 1'b0;
        end else if (ce_i && run) begin
            if (!advance || !started) begin
                msb_last_q <= 1'b0;
                half_sq_q  <= 1'b0;
            end else begin
                msb_last_q <= data_msb;
                if (msb_rise) half_sq_q <= ~half_sq_q;
            end
        end
    end

    // output freezes during clock sleep; register changes then show later
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wave_out_o <= `DWC_MIDSCALE;
        end else if (ce_i && run) begin
            wave_out_o <= wave_d;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            converter_sleep_o <= 1'b0;
            clock_running_o   <= 1'b1;
        end else if (ce_i) begin
            converter_sleep_o <= ctrl_q.converter_sleep;
            clock_running_o   <= run;
        end
    end

endmodule

`default_nettype wire

// ==== bench/dwc_core_asserts.sv ====
// concurrent port checks for the waveform core
`timescale 1ns/10ps
`default_nettype none
`include "dwc_defs.svh"

module dwc_core_asserts
    import dwc_pkg::*;
(
    // clock, reset, enable
    input  wire logic                     sys_clk_i,
    input  wire logic                     nrst_i,
    input  wire logic                     ce_i,
    // serial pins
    input  wire logic                     sclk_i,
    input  wire logic                     frame_sync_n_i,
    input  wire logic                     serial_in_i,
    // outputs
    input  wire logic [`DWC_DAC_BITS-1:0] wave_out_o,
    input  wire logic                     converter_sleep_o,
    input  wire logic                     clock_running_o
);
    logic [4:0] idle_q;
    logic [4:0] falls_q;
    logic       sclk_q;
    logic       fs_q;
    wire  logic fall_w;
    wire  logic start_w;

    assign fall_w  = sclk_q & ~sclk_i & ~frame_sync_n_i & (falls_q != 5'h1f);
    assign start_w = fs_q & ~frame_sync_n_i;

    // frame idle time and falling serial clock edges of the latest frame
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            idle_q  <= 5'h00;
            falls_q <= 5'h00;
            sclk_q  <= 1'b1;
            fs_q    <= 1'b1;
        end else begin
            sclk_q  <= sclk_i;
            fs_q    <= frame_sync_n_i;
            idle_q  <= !frame_sync_n_i ? 5'h00 : idle_q + {4'h0, idle_q != 5'h1f};
            falls_q <= start_w ? 5'h00 : falls_q + {4'h0, fall_w};
        end
    end

    default clocking @(posedge sys_clk_i); endclocking

    rst_midscale_a: assert property (!nrst_i |-> wave_out_o == `DWC_MIDSCALE)
        else $error("wave not midscale during reset");
    rst_power_a: assert property (!nrst_i |-> !converter_sleep_o && clock_running_o)
        else $error("power flags wrong during reset");
    rst_release_a: assert property ($rose(nrst_i) |-> (wave_out_o == `DWC_MIDSCALE) [*8])
        else $error("wave left midscale early after reset");
    rst_wake_a: assert property ($rose(nrst_i) |-> ##9 wave_out_o != `DWC_MIDSCALE)
        else $error("wave still midscale after reset delay");
    ce_freeze_a: assert property (disable iff (!nrst_i) !ce_i |=>
        $stable(wave_out_o) && $stable(clock_running_o) && $stable(converter_sleep_o))
        else $error("outputs moved with enable low");
    sleep_hold_a: assert property (disable iff (!nrst_i)
        !clock_running_o [*3] |-> $stable(wave_out_o))
        else $error("wave moved while clock asleep");
    run_idle_a: assert property (disable iff (!nrst_i) idle_q >= 5'h0c |-> $stable(clock_running_o))
        else $error("clock flag changed with no write");
    sleep_word_a: assert property (disable iff (!nrst_i) $changed(converter_sleep_o) |->
        falls_q >= 5'h10 && idle_q < 5'h0c)
        else $error("converter flag changed without full word");
    run_word_a: assert property (disable iff (!nrst_i) $changed(clock_running_o) |-> falls_q >= 5'h10)
        else $error("clock flag changed without full word");

    cover property (!clock_running_o);
    cover property (converter_sleep_o);
    cover property (wave_out_o == 10'h3ff);
    cover property (!ce_i);
endmodule
`default_nettype wire

// ==== bench/dwc_host_model.sv ====
// host model driving framed 16-bit serial writes
`timescale 1ns/10ps
`default_nettype none

module dwc_host_model
    import dwc_pkg::*;
(
    // master clock
    input  wire logic    sys_clk_i,
    // serial pins towards the core
    output var dwc_pins_t pins_o
);
    initial pins_o = '{sclk: 1'b1, frame_sync_n: 1'b1, serial_in: 1'b0};

    // msb first; fewer than 16 bits makes an aborted frame
    task automatic send(input logic [15:0] word, input int nbits);
        @(posedge sys_clk_i);
        pins_o.frame_sync_n <= 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            repeat (3) @(posedge sys_clk_i);
            pins_o.serial_in <= word[i];
            pins_o.sclk      <= 1'b1;
            repeat (3) @(posedge sys_clk_i);
            pins_o.sclk      <= 1'b0;
        end
        repeat (3) @(posedge sys_clk_i);
        pins_o.sclk         <= 1'b1;
        pins_o.frame_sync_n <= 1'b1;
        // released data line has no pull, so it must not keep the last bit
        pins_o.serial_in    <= ~pins_o.serial_in;
        repeat (4) @(posedge sys_clk_i);
    endtask
endmodule
`default_nettype wire

// ==== bench/dwc_core_tb_top.sv ====
// self-checking bench for the waveform core
`timescale 1ns/10ps
`default_nettype none
`include "dwc_defs.svh"

module dwc_core_tb_top
    import dwc_pkg::*;
;
    logic                     sys_clk_i  = 1'b0;
    logic                     nrst_i     = 1'b1;
    logic                     ce_i       = 1'b1;
    dwc_pins_t                pins;
    logic [`DWC_DAC_BITS-1:0] wave;
    logic                     dac_sleep;
    logic                     running;
    int                       err_total  = 0;
    int                       num_checks = 0;
    int                       cycles     = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    dwc_host_model i_host (.sys_clk_i(sys_clk_i), .pins_o(pins));

    dwc_core i_dut (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .sclk_i(pins.sclk),
        .frame_sync_n_i(pins.frame_sync_n), .serial_in_i(pins.serial_in),
        .wave_out_o(wave), .converter_sleep_o(dac_sleep), .clock_running_o(running));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] w);
        i_host.send(w, 16);
    endtask

    task automatic wave_is(input int n, input logic [9:0] exp);
        repeat (n) @(posedge sys_clk_i);
        #1;
        check("wave_out_o", {6'h00, wave}, {6'h00, exp});
    endtask

    // output changes over 64 cycles give the output rate
    task automatic toggles_are(input logic [15:0] exp);
        int         c;
        logic [9:0] last;
        c = 0;
        repeat (12) @(posedge sys_clk_i);
        #1;
        last = wave;
        repeat (64) begin
            @(posedge sys_clk_i);
            #1;
            c += int'(wave !== last);
            last = wave;
        end
        check("wave toggles", 16'(c), exp);
    endtask

    task automatic flags_are(input logic run, input logic slp);
        #1;
        check("clock_running_o", {15'h0000, running}, {15'h0000, run});
        check("converter_sleep_o", {15'h0000, dac_sleep}, {15'h0000, slp});
    endtask

    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        nrst_i <= 1'b0;         // negedge at time zero loads the async reset
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        wave_is(1, 10'h200);
        flags_are(1'b1, 1'b0);
        $display("test reset done");
        wr(16'h0100);
        wr(16'hc300);
        wr(16'hf900);
        wr(16'h0002);
        wave_is(0, 10'h200);
        wave_is(12, 10'h180);
        wr(16'h0402);
        wave_is(4, 10'h37f);
        i_host.send(16'h0000, 8);
        wave_is(4, 10'h37f);
        wr(16'he800);
        wr(16'h0400);
        wave_is(4, 10'h1f2);
        wr(16'hc000);
        wr(16'h0000);
        wave_is(4, 10'h20d);
        $display("test phase done");
        wr(16'h2100);
        wr(16'h4000);
        wr(16'h5000);
        wr(16'h8000);
        wr(16'h8800);
        wr(16'h2028);
        toggles_are(16'h0020);
        wr(16'h2828);
        toggles_are(16'h0010);
        wr(16'h2820);
        toggles_are(16'h0008);
        wr(16'h1828);
        wr(16'h9000);
        toggles_are(16'h0020);
        $display("test frequency done");
        wr(16'h20a8);
        flags_are(1'b0, 1'b0);
        wr(16'h28e8);
        wr(16'h8000);
        wr(16'h8800);
        flags_are(1'b0, 1'b1);
        toggles_are(16'h0000);
        wr(16'h2828);
        flags_are(1'b1, 1'b0);
        toggles_are(16'h0010);
        wr(16'h2868);
        flags_are(1'b1, 1'b1);
        $display("test sleep done");
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        toggles_are(16'h0000);
        @(posedge sys_clk_i);
        ce_i <= 1'b1;
        wr(16'h2128);
        wave_is(0, 10'h200);
        wr(16'h2028);
        toggles_are(16'h0020);
        $display("test enable and soft reset done");
        report_and_stop();
    end
endmodule

bind dwc_core dwc_core_asserts i_chk (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .sclk_i(sclk_i),
    .frame_sync_n_i(frame_sync_n_i), .serial_in_i(serial_in_i), .wave_out_o(wave_out_o),
    .converter_sleep_o(converter_sleep_o), .clock_running_o(clock_running_o));
`default_nettype wire
